//--- design/ima_pkg.sv
// Package of constants for the interrupt mode arbiter
package ima_pkg;
	// Control modes
	localparam logic [1:0] IMA_MODE_0 = 2'h0;
	localparam logic [1:0] IMA_MODE_2 = 2'h2;
	// Number of maskable sources and level width
	localparam int IMA_NSRC = 8;
	localparam int IMA_LVLW = 3;
	localparam logic [2:0] IMA_LVL_MAX = 3'h7;
	// Vector numbers and vector-table spacing
	localparam logic [7:0] IMA_NMI_VEC = 8'h07;
	localparam logic [7:0] IMA_SRC_VEC0 = 8'h10;
	localparam int IMA_VEC_SHIFT = 2;
	// Priority determination states
	localparam int IMA_EXT_STATES = 3;
	localparam int IMA_INT_STATES = 2;
	// Register offsets (byte addresses)
	localparam logic [11:0] IMA_OFF_SYSCTL = 12'h000;
	localparam logic [11:0] IMA_OFF_MASK = 12'h004;
	localparam logic [11:0] IMA_OFF_ENABLE = 12'h008;
	localparam logic [11:0] IMA_OFF_PRIO = 12'h00C;
	localparam logic [11:0] IMA_OFF_DTCSEL = 12'h010;
	localparam logic [11:0] IMA_OFF_STATUS = 12'h014;
	// Field positions
	localparam int IMA_SYS_MODE_LSB = 0;
	localparam int IMA_MASK_I_BIT = 3;
	// Reset values
	localparam logic [31:0] IMA_RST_PRIO = 32'h0000_0000;
endpackage

//--- design/ima_top.sv
// Interrupt mode arbiter: fixed-priority mode 0 and eight-level mode 2
`timescale 1ns/1ps
// Function
// R1 - Two modes, 0 and 2, selected by the system control register.
// R2 - Mode 0 uses fixed order; global mask bit masks all but NMI.
// R3 - Mode 2 gives each source one of eight levels, masked by level field.
// R4 - A source requests only while its enable bit is 1.
// R5 - Mode 0: mask bit 1 accepts only NMI; mask 0 accepts requests.
// R6 - Mode 0: highest fixed-order pending request wins, others stay pending.
// R7 - CPU starts handling only after its current instruction completes.
// R8 - Mode 0: CPU stacks PC and condition codes, PC is resume address.
// R9 - Mode 0: CPU sets global mask bit after stacking.
// R10 - Accepted request yields a vector address; CPU jumps through it.
// R11 - Mode 2: highest level wins; ties use fixed order.
// R12 - Mode 2: accept only when level strictly above mask level.
// R13 - Mode 2: CPU stacks PC, condition codes and extended control.
// R14 - Mode 2: CPU clears trace, loads mask with level or seven for NMI.
// R15 - Priority determination takes three states external, two internal.
// R16 - Instruction end wait is one to nineteen states plus two fetches.
// R17 - Stack save uses two accesses in mode 0, three in mode 2.
// R18 - Response includes two fetches and two internal states.
// R19 - A request may trigger the data transfer controller instead.
// R20 - Vector table entry address is four times vector number.
// R21 - Mode is static configuration, mode 0 after reset.
module ima_top
	import ima_pkg::*;
#(
	parameter int NSRC = ima_pkg::IMA_NSRC
)(
	// Clock and reset
	input  wire logic                     CLK_I,
	input  wire logic                     SYS_RST_I,
	// APB slave
	input  wire logic                     PSEL_I,
	input  wire logic                     PENABLE_I,
	input  wire logic                     PWRITE_I,
	input  wire logic [11:0]              PADDR_I,
	input  wire logic [31:0]              PWDATA_I,
	output logic      [31:0]              PRDATA_O,
	output logic                          PREADY_O,
	output logic                          PSLVERR_O,
	// Sources: NMI and maskable events, bit 0 highest fixed priority
	input  wire logic                     NMI_I,
	input  wire logic [ima_pkg::IMA_NSRC-1:0] SRC_I,
	input  wire logic [ima_pkg::IMA_NSRC-1:0] SRC_EXT_I,
	// CPU core side
	input  wire logic                     CPU_ACK_I,
	output logic                          CPU_REQ_O,
	output logic      [15:0]              CPU_VEC_ADDR_O,
	output logic      [2:0]               CPU_LEVEL_O,
	output logic                          CPU_NMI_O,
	// Data transfer controller side
	output logic      [ima_pkg::IMA_NSRC-1:0] XFER_START_O
);
	import ima_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Register state
	logic [1:0]        mode_ff, nxt_mode;
	logic              imask_ff, nxt_imask;
	logic [2:0]        lmask_ff, nxt_lmask;
	logic [NSRC-1:0]   en_ff, nxt_en;
	logic [NSRC-1:0]   dsel_ff, nxt_dsel;
	logic [31:0]       prio_ff, nxt_prio;
	logic [31:0]       prdata_ff, nxt_prdata;
	logic              pready_ff, nxt_pready;
	logic              pslverr_ff, nxt_pslverr;
	// Winner of the last determination; declared here since status reads it
	logic              req_ff, nxt_req;
	logic              nmi_ff, nxt_nmi;
	logic [2:0]        lvl_ff, nxt_lvl;
	logic [7:0]        vec_ff, nxt_vec;

	// Level of source i from its three-bit priority field
	function automatic logic [2:0] lvl_of(input logic [31:0] p, input int i);
		lvl_of = p[i*4 +: 3];
	endfunction

	// Vector address is four times the vector number
	function automatic logic [15:0] vec_addr(input logic [7:0] vn);
		vec_addr = {6'h00, vn, 2'h0}; // R20
	endfunction

	wire logic acc_phase = PSEL_I && PENABLE_I && !pready_ff;

	// Bus decode; one access completes per access phase, after one wait state
	always_comb begin
		nxt_mode    = mode_ff;
		nxt_imask   = imask_ff;
		nxt_lmask   = lmask_ff;
		nxt_en      = en_ff;
		nxt_dsel    = dsel_ff;
		nxt_prio    = prio_ff;
		nxt_prdata  = prdata_ff;
		nxt_pready  = acc_phase;
		nxt_pslverr = 1'b0;
		if (acc_phase) begin
			unique case (PADDR_I)
				IMA_OFF_SYSCTL: begin
					// Only the two legal codes are stored; other codes keep the mode
					if (PWRITE_I && (PWDATA_I[1:0] == IMA_MODE_0 ||
						PWDATA_I[1:0] == IMA_MODE_2)) begin
						nxt_mode = PWDATA_I[1:0]; // R1 R21
					end
					nxt_prdata = {30'h0000_0000, mode_ff};
				end
				IMA_OFF_MASK: begin
					if (PWRITE_I) begin
						nxt_lmask = PWDATA_I[2:0];
						nxt_imask = PWDATA_I[IMA_MASK_I_BIT];
					end
					nxt_prdata = {28'h000_0000, imask_ff, lmask_ff};
				end
				IMA_OFF_ENABLE: begin
					if (PWRITE_I) begin
						nxt_en = PWDATA_I[NSRC-1:0];
					end
					nxt_prdata = {{(32-NSRC){1'b0}}, en_ff};
				end
				IMA_OFF_PRIO: begin
					if (PWRITE_I) begin
						nxt_prio = PWDATA_I; // R3
					end
					nxt_prdata = prio_ff;
				end
				IMA_OFF_DTCSEL: begin
					if (PWRITE_I) begin
						nxt_dsel = PWDATA_I[NSRC-1:0];
					end
					nxt_prdata = {{(32-NSRC){1'b0}}, dsel_ff};
				end
				IMA_OFF_STATUS: begin
					// Pending flag at bit 15, level at bits 10 to 8, vector number below
					nxt_prdata = {16'h0000, req_ff, 4'h0, lvl_ff, vec_ff};
				end
				default: begin
					nxt_prdata  = 32'h0000_0000;
					nxt_pslverr = 1'b1;
				end
			endcase
		end
		// CPU mask update after acceptance, mirroring the core's own stacking
		if (req_ff && CPU_ACK_I) begin
			if (mode_ff == IMA_MODE_0) begin
				nxt_imask = 1'b1; // R9
			end else begin
				nxt_lmask = nmi_ff ? IMA_LVL_MAX : lvl_ff; // R14
			end
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			mode_ff    <= IMA_MODE_0;
			imask_ff   <= 1'b1;
			lmask_ff   <= IMA_LVL_MAX;
			en_ff      <= '0;
			dsel_ff    <= '0;
			prio_ff    <= IMA_RST_PRIO;
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			mode_ff    <= nxt_mode;
			imask_ff   <= nxt_imask;
			lmask_ff   <= nxt_lmask;
			en_ff      <= nxt_en;
			dsel_ff    <= nxt_dsel;
			prio_ff    <= nxt_prio;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Arbitration
	logic [NSRC-1:0] gated;
	logic            sel_v;
	logic [7:0]      sel_idx;
	logic [2:0]      sel_lvl;
	logic            sel_ext;
	logic            take;

	// Gate by enable; transfer-routed sources never reach the CPU
	always_comb begin
		gated   = SRC_I & en_ff & ~dsel_ff; // R4 R19
		sel_v   = 1'b0;
		sel_idx = 8'h00;
		sel_lvl = 3'h0;
		sel_ext = 1'b0;
		// Scan low index first so ties keep the fixed default order
		for (int i = 0; i < NSRC; i++) begin
			if (gated[i]) begin
				if (mode_ff == IMA_MODE_0) begin
					if (!sel_v) begin
						sel_v = 1'b1; // R2 R6
						sel_idx = 8'(i);
						sel_ext = SRC_EXT_I[i];
					end
				end else if (!sel_v || lvl_of(prio_ff, i) > sel_lvl) begin
					sel_v   = 1'b1; // R11
					sel_idx = 8'(i);
					sel_lvl = lvl_of(prio_ff, i);
					sel_ext = SRC_EXT_I[i];
				end
			end
		end
		if (mode_ff == IMA_MODE_0) begin
			take = sel_v && !imask_ff; // R5
		end else begin
			take = sel_v && (sel_lvl > lmask_ff); // R12
		end
	end

	////////////////////////////////////////////////////////////////////
	// Priority determination and hand-over to the CPU
	typedef enum {IMA_IDLE, IMA_DET, IMA_REQ} ima_st_t;
	ima_st_t         st_ff, nxt_st;
	logic [1:0]      cnt_ff, nxt_cnt;
	logic [15:0]     vaddr_ff, nxt_vaddr;
	// Transfer starts bypass determination entirely, one cycle behind the pins
	logic [NSRC-1:0] xfer_ff, nxt_xfer;

	// Determination lasts three states for pins, two for peripherals
	always_comb begin
		nxt_st    = st_ff;
		nxt_cnt   = cnt_ff;
		nxt_req   = req_ff;
		nxt_nmi   = nmi_ff;
		nxt_lvl   = lvl_ff;
		nxt_vec   = vec_ff;
		nxt_vaddr = vaddr_ff;
		nxt_xfer  = SRC_I & en_ff & dsel_ff; // R19
		unique case (st_ff)
			IMA_IDLE: begin
				if (NMI_I) begin
					nxt_st  = IMA_DET;
					nxt_cnt = 2'(IMA_EXT_STATES - 1); // R15
					nxt_nmi = 1'b1;
				end else if (take) begin
					nxt_st  = IMA_DET;
					nxt_cnt = sel_ext ? 2'(IMA_EXT_STATES - 1) : 2'(IMA_INT_STATES - 1); // R15
					nxt_nmi = 1'b0;
				end
			end
			IMA_DET: begin
				// Rearbitrate each state; a vanished maskable request returns to idle, an NMI runs on
				if (!nmi_ff && !take) begin
					nxt_st = IMA_IDLE;
				end else if (cnt_ff == 2'h1) begin
					nxt_st    = IMA_REQ;
					nxt_req   = 1'b1;
					nxt_lvl   = nmi_ff ? IMA_LVL_MAX : sel_lvl;
					nxt_vec   = nmi_ff ? IMA_NMI_VEC : IMA_SRC_VEC0 + sel_idx;
					nxt_vaddr = vec_addr(nxt_vec); // R10 R20
				end else begin
					nxt_cnt = cnt_ff - 2'h1;
				end
			end
			IMA_REQ: begin
				// Held until the core finishes its instruction and acknowledges
				if (CPU_ACK_I) begin // R7
					nxt_st  = IMA_IDLE;
					nxt_req = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			st_ff    <= IMA_IDLE;
			cnt_ff   <= 2'h0;
			req_ff   <= 1'b0;
			nmi_ff   <= 1'b0;
			lvl_ff   <= 3'h0;
			vec_ff   <= 8'h00;
			vaddr_ff <= 16'h0000;
			xfer_ff  <= '0;
		end else begin
			st_ff    <= nxt_st;
			cnt_ff   <= nxt_cnt;
			req_ff   <= nxt_req;
			nmi_ff   <= nxt_nmi;
			lvl_ff   <= nxt_lvl;
			vec_ff   <= nxt_vec;
			vaddr_ff <= nxt_vaddr;
			xfer_ff  <= nxt_xfer;
		end
	end

	// Outputs straight from flip-flops
	assign PRDATA_O       = prdata_ff;
	assign PREADY_O       = pready_ff;
	assign PSLVERR_O      = pslverr_ff;
	assign CPU_REQ_O      = req_ff;
	assign CPU_VEC_ADDR_O = vaddr_ff;
	assign CPU_LEVEL_O    = lvl_ff;
	assign CPU_NMI_O      = nmi_ff;
	assign XFER_START_O   = xfer_ff;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);

	a_mode0_mask_hold: assert property ((mode_ff == IMA_MODE_0 && imask_ff && !NMI_I
		&& st_ff == IMA_IDLE) |=> st_ff == IMA_IDLE) // R5
		else $error("mode 0 masked request started");
	a_mode2_level_gate: assert property ((mode_ff == IMA_MODE_2 && st_ff == IMA_REQ
		&& !nmi_ff) |-> lvl_ff > $past(lmask_ff)) // R12
		else $error("mode 2 level not above mask");
	a_ext_det_three: assert property ((st_ff == IMA_IDLE && NMI_I) |=> st_ff == IMA_DET
		##1 st_ff == IMA_DET ##1 st_ff == IMA_REQ) // R15
		else $error("NMI determination not three states");
	a_vec_addr_map: assert property (CPU_REQ_O |-> CPU_VEC_ADDR_O == {6'h00, vec_ff, 2'h0})
		// R20
		else $error("vector address not four times number");
	a_nmi_vector: assert property ((CPU_REQ_O && CPU_NMI_O) |-> vec_ff == IMA_NMI_VEC
		&& CPU_LEVEL_O == IMA_LVL_MAX) // R10
		else $error("NMI vector or level wrong");
	a_req_hold_ack: assert property ((CPU_REQ_O && !CPU_ACK_I) |=> CPU_REQ_O
		&& $stable(CPU_VEC_ADDR_O)) // R7
		else $error("request dropped before acknowledge");
	a_mode0_set_mask: assert property ((CPU_REQ_O && CPU_ACK_I && mode_ff == IMA_MODE_0)
		|=> imask_ff) // R9
		else $error("mask bit not set on acceptance");
	a_mode2_load_mask: assert property ((CPU_REQ_O && CPU_ACK_I && mode_ff == IMA_MODE_2)
		|=> lmask_ff == $past(lvl_ff)) // R14
		else $error("mask level not loaded");
	a_xfer_no_cpu: assert property ((st_ff == IMA_IDLE && !NMI_I && (SRC_I & en_ff) != '0
		&& (SRC_I & en_ff & ~dsel_ff) == '0) |=> st_ff == IMA_IDLE) // R19
		else $error("transfer-routed source reached CPU");
	a_apb_one_wait: assert property ((PSEL_I && PENABLE_I && !PREADY_O) |=> PREADY_O)
		else $error("APB answer late");

	// Main scenarios: NMI, level-based acceptance, transfer start, bad address
	c_nmi_taken: cover property (CPU_REQ_O && CPU_NMI_O && CPU_ACK_I);
	c_mode2_taken: cover property (CPU_REQ_O && mode_ff == IMA_MODE_2 && CPU_ACK_I);
	c_xfer_start: cover property (XFER_START_O != '0);
	c_bad_addr: cover property (PSLVERR_O);
endmodule // ima_top

//--- test/ima_cpu_model.sv
// CPU core model that acknowledges arbiter requests at instruction end
`timescale 1ns/1ps
module ima_cpu_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Request, active mode and length of the running instruction tail
	input  wire logic       req_i,
	input  wire logic       mode2_i,
	input  wire logic [4:0] dly_i,
	// Acknowledge pulse
	output logic            ack_o
);
	int cnt;
	int busy;
	////////////////////////////////////////
	// Ack once the current instruction has run out; never ack twice in a row
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			cnt <= 0;
			busy <= 0;
		end else begin
			ack_o <= 1'b0;
			if (busy > 0) begin
				// Exception sequence still running: no new acceptance
				busy <= busy - 1;
			end else if (req_i && !ack_o) begin
				if (cnt >= dly_i) begin
					ack_o <= 1'b1;
					cnt <= 0;
					// Stack pushes (PC, condition codes, extended control in mode 2),
					// then vector fetch, two instruction fetches, two internal states
					busy <= (mode2_i ? 3 : 2) + 5;
				end else begin
					cnt <= cnt + 1;
				end
			end
		end
	end
endmodule // ima_cpu_model

//--- test/tb_top.sv
// Self-checking bench for the interrupt mode arbiter
`timescale 1ns/1ps
module tb_top;
	import ima_pkg::*;
	logic        clk, rst, psel, pen, pwr, nmi, ack, err;
	logic        pready, pslverr, req, cnmi, nm, acc;
	logic [11:0] padr;
	logic [31:0] pwd, prd, rd, wd, en, md, mreg;
	logic [15:0] vec;
	logic [7:0]  src, ext, xfs, src_v, ext_v;
	logic [4:0]  dly;
	logic [2:0]  lvl, exp_lvl;
	int          err_total, comparisons, cyc, n, best;
	int          lv[8];

	ima_top i_dut (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .NMI_I(nmi), .SRC_I(src),
		.SRC_EXT_I(ext), .CPU_ACK_I(ack), .CPU_REQ_O(req), .CPU_VEC_ADDR_O(vec),
		.CPU_LEVEL_O(lvl), .CPU_NMI_O(cnmi), .XFER_START_O(xfs));
	ima_cpu_model i_cpu (.clk_i(clk), .rst_i(rst), .req_i(req), .mode2_i(md[1]),
		.dly_i(dly), .ack_o(ack));

	////////////////////////////////////////
	// Clock and hang guard
	initial clk = 1'b0;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			final_report();
		end
	end

	task automatic chk(input string nm_s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm_s, e, g);
		end
	endtask

	// APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prd;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	task automatic final_report;
		if (err_total == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	////////////////////////////////////////
	// Main sequence
	initial begin
		{psel, pen, pwr, nmi} = 4'h0;
		padr = 12'h000;
		pwd = 32'h0000_0000;
		src = 8'h00;
		ext = 8'h00;
		dly = 5'h01;
		md = 32'h0000_0000;
		rst = 1'b1;
		wd = $urandom(32'h5bc8a32f);
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// Reset values, then one unmapped word
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0000_0000);
			chk("reset value", (i == 1) ? 32'h0000_000F : 32'h0000_0000, rd);
			chk("slverr", (i == 6), err);
		end
		apb(1'b1, IMA_OFF_SYSCTL, 32'h0000_0001);
		apb(1'b0, IMA_OFF_SYSCTL, 32'h0000_0000);
		chk("mode", 32'h0000_0000, rd);
		// Routed sources start transfers and never reach the CPU
		wd = $urandom;
		apb(1'b1, IMA_OFF_MASK, 32'h0000_0000);
		apb(1'b1, IMA_OFF_ENABLE, 32'h0000_00FF);
		apb(1'b1, IMA_OFF_DTCSEL, {24'h00_0000, wd[7:0]});
		@(posedge clk);
		src <= wd[7:0] & wd[15:8];
		@(posedge clk);
		#1 chk("transfer start", wd[7:0] & wd[15:8], xfs);
		repeat (4) @(posedge clk);
		#1 chk("transfer no request", 32'h0000_0000, req);
		@(posedge clk);
		src <= 8'h00;
		apb(1'b1, IMA_OFF_DTCSEL, 32'h0000_0000);
		// Random rounds alternating mode 0 and mode 2, NMI every fifth
		for (int k = 0; k < 60; k++) begin
			md = (k % 2) ? 32'h0000_0002 : 32'h0000_0000;
			wd = $urandom;
			en = $urandom;
			mreg = $urandom % 16;
			src_v = 8'($urandom);
			ext_v = 8'($urandom);
			nm = (k % 5 == 0);
			apb(1'b1, IMA_OFF_SYSCTL, md);
			apb(1'b1, IMA_OFF_PRIO, wd);
			apb(1'b1, IMA_OFF_ENABLE, en);
			apb(1'b1, IMA_OFF_MASK, mreg);
			best = -1;
			for (int i = 0; i < 8; i++) begin
				lv[i] = wd[4*i +: 3];
				if (src_v[i] && en[i] && (best < 0 || (md == 2 && lv[i] > lv[best]))) begin
					best = i;
				end
			end
			acc = nm || (best >= 0 && ((md == 2) ? (lv[best] > mreg[2:0]) : !mreg[3]));
			exp_lvl = nm ? 3'h7 : ((md == 2 && best >= 0) ? 3'(lv[best]) : 3'h0);
			@(posedge clk);
			src <= src_v;
			ext <= ext_v;
			nmi <= nm;
			dly <= 5'($urandom_range(1, 19));
			n = 0;
			do begin
				@(posedge clk);
				#1 n++;
			end while (req !== 1'b1 && n < 6);
			if (acc) begin
				chk("states", (nm || ext_v[best]) ? 3 : 2, n);
				chk("vector", nm ? 16'h001C : 16'(4 * (16 + best)), vec);
				chk("level", exp_lvl, lvl);
				chk("nmi flag", nm, cnmi);
			end else begin
				chk("no request", 32'h0000_0000, req);
			end
			@(posedge clk);
			src <= 8'h00;
			nmi <= 1'b0;
			n = 0;
			while (req !== 1'b0 && n < 40) begin
				@(posedge clk);
				#1 n++;
			end
			chk("request drop", 32'h0000_0000, req);
			if (acc) begin
				apb(1'b0, IMA_OFF_MASK, 32'h0000_0000);
				if (md == 2) begin
					chk("mask level", exp_lvl, rd[2:0]);
				end else begin
					chk("mask bit", 32'h0000_0001, rd[3]);
				end
			end
		end
		final_report();
	end
endmodule // tb_top
